// ### smr_consts.svh
// Constants of the synchronous master receive block
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH
`define SMR_AW 8
`define SMR_CHAR_W 9
`define SMR_OFF_CTRL 8'h00
`define SMR_OFF_STAT 8'h04
`define SMR_OFF_DATA 8'h08
`define SMR_OFF_BAUD 8'h0C
`define SMR_OFF_IST 8'h10
`define SMR_OFF_IMSK 8'h14
`define SMR_CTRL_PORT_EN 0
`define SMR_CTRL_SYNC 1
`define SMR_CTRL_MASTER 2
`define SMR_CTRL_SINGLE 3
`define SMR_CTRL_CONT 4
`define SMR_CTRL_NINE 5
`define SMR_CTRL_HSPD 6
`define SMR_CTRL_WIDE 7
`define SMR_STAT_NINTH 0
`define SMR_STAT_OVR 1
`define SMR_STAT_DONE 2
`define SMR_IST_RX 0
`define SMR_IST_OVR 1
`define SMR_CTRL_RST 8'h00
`define SMR_BAUD_RST 16'h0000
`define SMR_IMSK_RST 2'h0
`define SMR_IST_RST 2'h0
`define SMR_LAST8 4'h7
`define SMR_LAST9 4'h8
`define SMR_QDEPTH 2'h2
`endif

// ### smr_pkg.sv
// Types shared by the synchronous master receive block
`include "smr_consts.svh"
package smr_pkg;
   typedef enum logic [1:0] {SMR_IDLE, SMR_LOW, SMR_HIGH} smr_phase_t;
   typedef enum logic [2:0] {SMR_SEL_CTRL, SMR_SEL_STAT, SMR_SEL_DATA,
      SMR_SEL_BAUD, SMR_SEL_IST, SMR_SEL_IMSK, SMR_SEL_NONE} smr_sel_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] baud;
      logic [1:0] ist;
      logic [1:0] imask;
      logic overrun_error_flag;
      smr_phase_t phase;
      logic [15:0] cnt;
      logic [3:0] bitcnt;
      logic [`SMR_CHAR_W-1:0] shreg;
      logic [1:0] dsync;
      logic ck;
      logic ckoe;
      logic dtoe;
      logic pready;
      logic pslverr;
      logic pop_ok;
      logic [31:0] prdata;
      logic irq;
   } smr_state_t;
endpackage : smr_pkg

// ### smr_rx_queue.sv
// Two-entry receive character queue
`timescale 1ns/1ns
`include "smr_consts.svh"
module smr_rx_queue
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Control
   input wire logic clr,
   input wire logic push,
   input wire logic [`SMR_CHAR_W-1:0] push_data,
   input wire logic pop,
   // Status
   output logic [`SMR_CHAR_W-1:0] head,
   output logic empty,
   output logic full
);
   typedef struct packed {
      logic [1:0][`SMR_CHAR_W-1:0] mem;
      logic rd;
      logic [1:0] count;
   } smr_q_state_t;

   smr_q_state_t q_reg, q_next;
   logic do_pop, do_push, wr_idx;

   always_comb
   begin
      q_next = q_reg;
      do_pop = pop && (q_reg.count != 2'h0);
      do_push = push && ((q_reg.count != `SMR_QDEPTH) || do_pop);
      // Slot behind the oldest; a full queue reuses the slot being freed
      wr_idx = q_reg.rd ^ (q_reg.count == 2'h1);
      if (do_push)
      begin
         q_next.mem[wr_idx] = push_data;
      end
      if (do_pop)
      begin
         q_next.rd = ~q_reg.rd;
      end
      case ({do_push, do_pop})
         2'h2: q_next.count = q_reg.count + 2'h1;
         2'h1: q_next.count = q_reg.count - 2'h1;
         default: q_next.count = q_reg.count;
      endcase
      if (clr)
      begin
         q_next.rd = 1'h0;
         q_next.count = 2'h0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         q_reg <= '0;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   assign head = q_reg.mem[q_reg.rd];
   assign empty = (q_reg.count == 2'h0);
   assign full = (q_reg.count == `SMR_QDEPTH);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   queue_bound_a: assert property (q_reg.count <= `SMR_QDEPTH)
      else $error("receive queue holds more than two characters");
   queue_keep_a: assert property (full && !pop && !clr
      |=> full && head == $past(head))
      else $error("full queue lost or changed its oldest character");
endmodule : smr_rx_queue

// ### smr_top.sv
// Synchronous master serial receiver with APB registers
`timescale 1ns/1ns
`include "smr_consts.svh"
// What this block does
// - Nine-bit select adds ninth data bit
// - Completion sets flag, interrupt when enabled
// - Status read gives ninth bit, error flags
// - Data read gives low eight bits
// - Continuous or port disable clears overrun
// - Single gives one character; continuous runs
// - Trailing edge sampling into two-entry queue
// - Third character sets overrun, keeps data
// - Both enables: single clears, continuous continues
module smr_top
   import smr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SMR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins
   output logic shift_clock_pin_out,
   output logic shift_clock_pin_oe,
   input wire logic receive_data_pin_in,
   output logic receive_data_pin_out,
   output logic receive_data_pin_oe,
   // Interrupt
   output logic irq
);
   smr_state_t s_reg, s_next;
   logic q_push, q_pop, q_clr, q_empty, q_full;
   logic [`SMR_CHAR_W-1:0] q_head, char_w;
   logic setup, acc, wr, rd, active, done, ovr_set;
   logic [1:0] w1c;
   logic [3:0] last;
   logic [15:0] half;
   smr_sel_t sel;

   function automatic smr_sel_t reg_sel(input logic [`SMR_AW-1:0] a);
      case (a)
         `SMR_OFF_CTRL: reg_sel = SMR_SEL_CTRL;
         `SMR_OFF_STAT: reg_sel = SMR_SEL_STAT;
         `SMR_OFF_DATA: reg_sel = SMR_SEL_DATA;
         `SMR_OFF_BAUD: reg_sel = SMR_SEL_BAUD;
         `SMR_OFF_IST: reg_sel = SMR_SEL_IST;
         `SMR_OFF_IMSK: reg_sel = SMR_SEL_IMSK;
         default: reg_sel = SMR_SEL_NONE;
      endcase
   endfunction : reg_sel

   smr_rx_queue u_queue
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .clr(q_clr),
      .push(q_push),
      .push_data(char_w),
      .pop(q_pop),
      .head(q_head),
      .empty(q_empty),
      .full(q_full)
   );

   always_comb
   begin
      s_next = s_reg;
      q_push = 1'h0;
      q_pop = 1'h0;
      q_clr = 1'h0;
      done = 1'h0;
      ovr_set = 1'h0;
      w1c = 2'h0;
      char_w = s_reg.shreg;
      setup = psel && !penable;
      acc = psel && penable && s_reg.pready;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      sel = reg_sel(paddr);
      // Shift clock half period is divisor plus one system clocks
      half = s_reg.ctrl[`SMR_CTRL_WIDE] ? s_reg.baud :
         {8'h00, s_reg.baud[7:0]};
      last = s_reg.ctrl[`SMR_CTRL_NINE] ? `SMR_LAST9 : `SMR_LAST8;
      active = s_reg.ctrl[`SMR_CTRL_PORT_EN] && s_reg.ctrl[`SMR_CTRL_SYNC]
         && s_reg.ctrl[`SMR_CTRL_MASTER] && !s_reg.overrun_error_flag
         && (s_reg.ctrl[`SMR_CTRL_SINGLE]
         || s_reg.ctrl[`SMR_CTRL_CONT]);
      s_next.dsync = {s_reg.dsync[0], receive_data_pin_in};

      // Shift clock generator and sampler, idle low
      case (s_reg.phase)
         SMR_IDLE:
         begin
            s_next.cnt = 16'h0000;
            s_next.bitcnt = 4'h0;
            s_next.ck = 1'h0;
            if (active)
            begin
               s_next.phase = SMR_LOW;
            end
         end
         SMR_LOW:
         begin
            if (s_reg.cnt == half)
            begin
               s_next.cnt = 16'h0000;
               s_next.ck = 1'h1;
               s_next.phase = SMR_HIGH;
            end
            else
            begin
               s_next.cnt = s_reg.cnt + 16'h0001;
            end
         end
         SMR_HIGH:
         begin
            if (s_reg.cnt == half)
            begin
               // Trailing edge: take the bit, least significant first
               s_next.cnt = 16'h0000;
               s_next.ck = 1'h0;
               char_w[s_reg.bitcnt] = s_reg.dsync[1];
               s_next.shreg = char_w;
               if (s_reg.bitcnt == last)
               begin
                  done = 1'h1;
                  s_next.phase = SMR_IDLE;
               end
               else
               begin
                  s_next.bitcnt = s_reg.bitcnt + 4'h1;
                  s_next.phase = SMR_LOW;
               end
            end
            else
            begin
               s_next.cnt = s_reg.cnt + 16'h0001;
            end
         end
         default:
         begin
            s_next.phase = SMR_IDLE;
            s_next.ck = 1'h0;
         end
      endcase
      if (!active && s_reg.phase != SMR_IDLE)
      begin
         // Enable dropped mid character: clock stops, bits are dropped
         done = 1'h0;
         s_next.phase = SMR_IDLE;
         s_next.ck = 1'h0;
      end
      if (!s_reg.ctrl[`SMR_CTRL_CONT] && !s_reg.ctrl[`SMR_CTRL_SINGLE])
      begin
         s_next.shreg = '0;
      end
      if (done)
      begin
         s_next.ctrl[`SMR_CTRL_SINGLE] = 1'h0;
      end

      // APB: answer is registered, ready in the first access cycle, no wait state
      s_next.pready = setup;
      s_next.pslverr = setup && (sel == SMR_SEL_NONE);
      if (setup)
      begin
         s_next.pop_ok = (sel == SMR_SEL_DATA) && !pwrite && !q_empty;
         case (sel)
            SMR_SEL_CTRL: s_next.prdata = {24'h00_0000, s_reg.ctrl};
            SMR_SEL_STAT:
            begin
               s_next.prdata = 32'h0000_0000;
               s_next.prdata[`SMR_STAT_NINTH] = !q_empty
                  && s_reg.ctrl[`SMR_CTRL_NINE] && q_head[8];
               s_next.prdata[`SMR_STAT_OVR] = s_reg.overrun_error_flag;
               s_next.prdata[`SMR_STAT_DONE] = !q_empty;
            end
            SMR_SEL_DATA:
               s_next.prdata = q_empty ? 32'h0000_0000 :
                  {24'h00_0000, q_head[7:0]};
            SMR_SEL_BAUD: s_next.prdata = {16'h0000, s_reg.baud};
            SMR_SEL_IST: s_next.prdata = {30'h0000_0000, s_reg.ist};
            SMR_SEL_IMSK: s_next.prdata = {30'h0000_0000, s_reg.imask};
            default: s_next.prdata = 32'h0000_0000;
         endcase
      end
      if (rd && sel == SMR_SEL_DATA)
      begin
         q_pop = s_reg.pop_ok;
         if (!s_reg.ctrl[`SMR_CTRL_CONT])
         begin
            s_next.overrun_error_flag = 1'h0;
         end
      end
      if (wr)
      begin
         case (sel)
            SMR_SEL_CTRL:
            begin
               s_next.ctrl = pwdata[7:0];
               if (!pwdata[`SMR_CTRL_CONT])
               begin
                  s_next.overrun_error_flag = 1'h0;
               end
            end
            SMR_SEL_BAUD: s_next.baud = pwdata[15:0];
            SMR_SEL_IST: w1c = pwdata[1:0];
            SMR_SEL_IMSK: s_next.imask = pwdata[1:0];
            default: s_next.imask = s_next.imask;
         endcase
      end
      if (!s_reg.ctrl[`SMR_CTRL_PORT_EN])
      begin
         // Port disabled: queue, overrun flag, bit counter and shift clock held in reset; ist is kept
         q_clr = 1'h1;
         s_next.overrun_error_flag = 1'h0;
         s_next.phase = SMR_IDLE;
         s_next.ck = 1'h0;
         s_next.bitcnt = 4'h0;
      end

      // Completed character: queue it, or flag overrun if no room
      ovr_set = done && q_full && !q_pop;
      q_push = done && !ovr_set;
      if (ovr_set)
      begin
         s_next.overrun_error_flag = 1'h1;
      end
      s_next.ist = (s_reg.ist & ~w1c) | {ovr_set, q_push};
      s_next.irq = |(s_next.ist & s_next.imask);
      s_next.ckoe = s_next.ctrl[`SMR_CTRL_PORT_EN]
         && s_next.ctrl[`SMR_CTRL_SYNC] && s_next.ctrl[`SMR_CTRL_MASTER];
      // Data pin driver stays off in master receive
      s_next.dtoe = 1'h0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_reg <= '0;
         s_reg.ctrl <= `SMR_CTRL_RST;
         s_reg.baud <= `SMR_BAUD_RST;
         s_reg.ist <= `SMR_IST_RST;
         s_reg.imask <= `SMR_IMSK_RST;
         s_reg.phase <= SMR_IDLE;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign shift_clock_pin_out = s_reg.ck;
   assign shift_clock_pin_oe = s_reg.ckoe;
   assign receive_data_pin_out = 1'h0;
   assign receive_data_pin_oe = s_reg.dtoe;
   assign irq = s_reg.irq;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   single_clear_a: assert property (done && !wr
      |=> !s_reg.ctrl[`SMR_CTRL_SINGLE])
      else $error("single receive enable not cleared after character");
   clock_stop_a: assert property (!active && s_reg.phase != SMR_IDLE
      |=> s_reg.phase == SMR_IDLE && !shift_clock_pin_out)
      else $error("shift clock kept running after enable dropped");
   char_len_a: assert property (done |-> s_reg.bitcnt ==
      (s_reg.ctrl[`SMR_CTRL_NINE] ? 4'h8 : 4'h7))
      else $error("character completed with wrong bit count");
   overrun_set_a: assert property (done && q_full && !q_pop
      |=> s_reg.overrun_error_flag && s_reg.ist[`SMR_IST_OVR] && !q_push)
      else $error("overrun not flagged on third character");
   overrun_hold_a: assert property (s_reg.overrun_error_flag && s_reg.phase == SMR_IDLE
      |=> !shift_clock_pin_out)
      else $error("reception went on while overrun stood");
   irq_raise_a: assert property (q_push && s_reg.imask[`SMR_IST_RX]
      && !(wr && sel == SMR_SEL_IMSK) |=> irq)
      else $error("interrupt missing after completed character");
   port_reset_a: assert property (!s_reg.ctrl[`SMR_CTRL_PORT_EN]
      |=> !s_reg.overrun_error_flag && q_empty && !shift_clock_pin_out)
      else $error("port disable did not reset the serial unit");
   cont_clear_a: assert property (wr && sel == SMR_SEL_CTRL
      && !pwdata[`SMR_CTRL_CONT] && !ovr_set |=> !s_reg.overrun_error_flag)
      else $error("overrun survived clearing continuous receive");
   data_clear_a: assert property (rd && sel == SMR_SEL_DATA
      && !s_reg.ctrl[`SMR_CTRL_CONT] && !ovr_set |=> !s_reg.overrun_error_flag)
      else $error("data read in single mode left overrun standing");
   ninth_read_a: assert property (setup && sel == SMR_SEL_STAT
      && s_reg.ctrl[`SMR_CTRL_NINE] && !q_empty
      |=> prdata[`SMR_STAT_NINTH] == $past(q_head[8]))
      else $error("status read gave wrong ninth bit");
   data_read_a: assert property (setup && sel == SMR_SEL_DATA && !q_empty
      |=> prdata[7:0] == $past(q_head[7:0]) && pready)
      else $error("data read gave wrong character");
endmodule : smr_top

// ### smr_slave_model.sv
// Behavioural serial slave that feeds characters to the receiver
`timescale 1ns/1ns
module smr_slave_model
(
   // Link
   input wire logic sck,
   input wire logic nine,
   output logic sdata
);
   logic [8:0] tx_q[$];
   logic [8:0] cur;
   int nbit;

   task restart;
      begin
         nbit = 0;
         tx_q.delete();
      end
   endtask : restart

   initial
   begin
      sdata = 1'b0;
      cur = 9'h000;
      nbit = 0;
   end

   // New bit on the leading edge, settled by the trailing edge, LSB first
   always @(posedge sck)
   begin
      if (nbit == 0)
         cur = (tx_q.size() > 0) ? tx_q.pop_front() : 9'h1A5;
      sdata = cur[nbit];
      nbit = (nbit == (nine ? 8 : 7)) ? 0 : nbit + 1;
   end

   // Hold runs out after the last trailing edge, so the line moves
   always @(negedge sck)
      if (nbit == 0)
         sdata = ~sdata;
endmodule : smr_slave_model

// ### sync_master_serial_receive_test.sv
// Bench for the receive block with its reference model
`timescale 1ns/1ns
`include "smr_consts.svh"
module sync_master_serial_receive_test;
   logic clk_sys, srst, psel, penable, pwrite, pready, pslverr;
   logic [`SMR_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sck, sck_oe, sdat, irq, nine_m, hi_seen;
   logic err, dt_out, dt_oe;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [8:0] exp_q[$];
   logic ovr_m = 1'b0;

   smr_top u_smr_top (.clk_sys(clk_sys), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shift_clock_pin_out(sck), .shift_clock_pin_oe(sck_oe),
      .receive_data_pin_in(sdat),
      .receive_data_pin_out(dt_out), .receive_data_pin_oe(dt_oe),
      .irq(irq));
   smr_slave_model u_smr_slave_model (.sck(sck), .nine(nine_m),
      .sdata(sdat));

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task close_out;
      begin
         $display("checks %0d mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask : close_out

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("wrong value at %0t: reg %h not %h", $time, got, exp);
         end
      end
   endtask : chk_reg

   task chk_pin(input logic got, input logic exp);
      begin
         n_tests++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("wrong value at %0t: pin %b not %b", $time, got, exp);
         end
      end
   endtask : chk_pin

   // One APB transfer held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      begin
         n = 0;
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge clk_sys);
         penable <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            n++;
         end
         while (pready !== 1'b1 && n < 50);
         if (n >= 50)
         begin
            n_mismatch++;
            close_out();
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk_sys);
      end
   endtask : apb

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      begin
         apb(1'b0, a, 32'h0000_0000);
         chk_reg(rd, exp);
      end
   endtask : rdc

   // Poll a register bit until it reaches the wanted level
   task wait_bit(input logic [7:0] a, input int b, input logic v);
      int n;
      begin
         n = 0;
         do
         begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
         end
         while (rd[b] !== v && n < 1000);
         chk_pin(rd[b], v);
         if (n >= 1000)
            close_out();
      end
   endtask : wait_bit

   // Reference model of the two-entry queue
   task send(input int n);
      logic [8:0] c;
      begin
         repeat (n)
         begin
            c = 9'($urandom) & (nine_m ? 9'h1FF : 9'h0FF);
            u_smr_slave_model.tx_q.push_back(c);
            if (exp_q.size() < 2)
               exp_q.push_back(c);
            else
               ovr_m = 1'b1;
         end
      end
   endtask : send

   task rd_status;
      begin
         rdc(`SMR_OFF_STAT, {29'h0, exp_q.size() > 0, ovr_m,
            exp_q.size() > 0 && exp_q[0][8]});
      end
   endtask : rd_status

   task rd_data;
      begin
         rdc(`SMR_OFF_DATA, exp_q.size() > 0 ? exp_q.pop_front() & 8'hFF : 0);
      end
   endtask : rd_data

   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      nine_m = 1'b0;
      void'($urandom(32'hb01c));
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rdc(`SMR_OFF_CTRL, 0);
      rdc(`SMR_OFF_IST, 0);
      rd_status();
      apb(1'b1, `SMR_OFF_BAUD, 32'h0000_1234);
      rdc(`SMR_OFF_BAUD, 32'h0000_1234);
      rdc(8'h18, 0);
      chk_pin(err, 1'b1);
      $display("test registers done");
      apb(1'b1, `SMR_OFF_BAUD, 32'd19);
      apb(1'b1, `SMR_OFF_IMSK, 32'd1);
      apb(1'b1, `SMR_OFF_CTRL, 8'h07);
      chk_pin(sck_oe, 1'b1);
      chk_pin(dt_oe, 1'b0);
      chk_pin(dt_out, 1'b0);
      send(1);
      apb(1'b1, `SMR_OFF_CTRL, 8'h0F);
      wait_bit(`SMR_OFF_CTRL, `SMR_CTRL_SINGLE, 1'b0);
      repeat (4) @(posedge clk_sys);
      chk_pin(irq, 1'b1);
      rdc(`SMR_OFF_IST, 1);
      rd_status();
      rd_data();
      rd_status();
      apb(1'b1, `SMR_OFF_IST, 32'd1);
      repeat (3) @(posedge clk_sys);
      chk_pin(irq, 1'b0);
      $display("test single done");
      apb(1'b1, `SMR_OFF_IMSK, 32'd0);
      apb(1'b1, `SMR_OFF_BAUD, 32'h0000_0013);
      nine_m <= 1'b1;
      @(posedge clk_sys);
      send(3);
      apb(1'b1, `SMR_OFF_CTRL, 8'hB7);
      wait_bit(`SMR_OFF_STAT, `SMR_STAT_OVR, 1'b1);
      chk_pin(irq, 1'b0);
      rdc(`SMR_OFF_IST, 3);
      apb(1'b1, `SMR_OFF_CTRL, 8'hA7);
      ovr_m = 1'b0;
      rd_status();
      rd_data();
      rd_status();
      rd_data();
      rd_status();
      apb(1'b1, `SMR_OFF_IST, 32'd3);
      u_smr_slave_model.restart();
      $display("test overrun done");
      nine_m <= 1'b0;
      apb(1'b1, `SMR_OFF_BAUD, 32'd19);
      send(1);
      apb(1'b1, `SMR_OFF_CTRL, 8'h1F);
      wait_bit(`SMR_OFF_CTRL, `SMR_CTRL_SINGLE, 1'b0);
      apb(1'b1, `SMR_OFF_CTRL, 8'h07);
      hi_seen = 1'b0;
      repeat (200)
      begin
         @(posedge clk_sys);
         hi_seen = hi_seen | (sck === 1'b1);
      end
      chk_pin(hi_seen, 1'b0);
      rd_status();
      rd_data();
      u_smr_slave_model.restart();
      $display("test both enables done");
      send(1);
      apb(1'b1, `SMR_OFF_CTRL, 8'h17);
      wait_bit(`SMR_OFF_STAT, `SMR_STAT_DONE, 1'b1);
      apb(1'b1, `SMR_OFF_CTRL, 8'h00);
      exp_q.delete();
      rd_status();
      chk_pin(sck_oe, 1'b0);
      $display("test port disable done");
      close_out();
   end
endmodule : sync_master_serial_receive_test
